/* rtl/usb_iso_endpoint_double_buffer.sv */
// Ping-pong buffer control for one isochronous endpoint of a device controller.
// Assumes frame_event, the processor side and the serial engine side all run on mclk,
// and that ep_dir_in is changed only while the endpoint is idle.
//
// Contract
// - Each frame event swaps the roles of the two packet buffers.
// - Commit and release commands never change the active buffer selection.
// - Bus traffic uses the inactive buffer while software uses the active one.
// - Unread OUT data in the active buffer is discarded at the swap.
// - Uncommitted IN active buffer is sent as zero-length packet after swap.
// - Stale uncommitted IN contents are dropped and overwritten when active again.
// - Both buffers of the pair are reserved in packet memory automatically.
// - Processor accesses are routed only to the active buffer.
`timescale 1ns/1ps
module usb_iso_endpoint_double_buffer (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    input  wire logic       ep_dir_in,
    input  wire logic       frame_event,
    input  wire logic       cpu_wr_valid,
    input  wire logic [7:0] cpu_wr_data,
    output logic            cpu_wr_ready,
    input  wire logic       cpu_commit,
    input  wire logic       cpu_release,
    input  wire logic       cpu_rd_req,
    output logic            cpu_rd_valid,
    output logic [7:0]      cpu_rd_data,
    output logic            cpu_rd_avail,
    output logic            active_sel,
    input  wire logic       se_rx_valid,
    input  wire logic [7:0] se_rx_data,
    output logic            se_tx_valid,
    output logic [7:0]      se_tx_data,
    output logic            se_tx_last,
    output logic            se_tx_zlp,
    input  wire logic       se_tx_ready
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]                  endpoint_packet_ram [0:2*iso_dbuf_pkg::PKT_DEPTH-1];
    logic [6:0]                  cnt [0:1];
    logic [6:0]                  next_cnt [0:1];
    logic                        committed [0:1];
    logic                        next_committed [0:1];
    logic                        next_active_sel;
    logic [6:0]                  rd_ptr, next_rd_ptr;     // Read count, one bit wider than the index
    logic                        next_cpu_wr_ready, next_cpu_rd_valid, next_cpu_rd_avail;
    logic [7:0]                  next_cpu_rd_data;
    logic                        ram_we;
    logic [6:0]                  ram_waddr;
    logic [7:0]                  ram_wdata;
    logic                        cpu_wr_take, cpu_rd_take, rx_take;
    iso_dbuf_pkg::tx_state_t     tx_state, next_tx_state;
    logic [6:0]                  tx_len, next_tx_len;
    logic [5:0]                  tx_ptr, next_tx_ptr;
    logic                        push, push_last, push_zlp;
    logic [7:0]                  push_data;
    logic                        skid_valid, skid_last, skid_zlp;
    logic [7:0]                  skid_data, next_skid_data;
    logic                        next_skid_valid, next_skid_last, next_skid_zlp;
    logic                        next_se_tx_valid, next_se_tx_last, next_se_tx_zlp;
    logic [7:0]                  next_se_tx_data;

    // ------------------------------------------------------------
    // Access qualification
    // ------------------------------------------------------------
    // Processor writes land in the active buffer of an IN endpoint only
    assign cpu_wr_take = cpu_wr_valid & cpu_wr_ready;
    // Reads only from the active buffer of an OUT endpoint, below its fill count
    assign cpu_rd_take = cpu_rd_req & ~ep_dir_in & (rd_ptr < cnt[active_sel]);
    // Received bytes beyond a full buffer are dropped; isochronous traffic cannot be refused
    assign rx_take     = se_rx_valid & ~ep_dir_in & (cnt[~active_sel] != iso_dbuf_pkg::CNT_FULL);

    // ------------------------------------------------------------
    // Packet memory write port
    // ------------------------------------------------------------
    // fixed halves
    // Each buffer owns a fixed half selected by the top address bit, so no allocation step exists
    always_comb begin
        ram_we    = 1'b0;
        ram_waddr = {active_sel, rd_ptr[5:0]};
        ram_wdata = iso_dbuf_pkg::DATA_ZERO;
        if (cpu_wr_take) begin
            ram_we    = 1'b1;
            ram_waddr = {active_sel, cnt[active_sel][5:0]};
            ram_wdata = cpu_wr_data;
        end else if (rx_take) begin
            ram_we    = 1'b1;
            ram_waddr = {~active_sel, cnt[~active_sel][5:0]};
            ram_wdata = se_rx_data;
        end
    end

    // Memory array, no reset needed as counts gate every read
    always_ff @(posedge mclk) begin
        if (clk_en && ram_we) begin
            endpoint_packet_ram[ram_waddr] <= ram_wdata;
        end
    end

    // ------------------------------------------------------------
    // Buffer roles, fill counts and commit flags
    // ------------------------------------------------------------
    always_comb begin
        next_active_sel = active_sel;
        next_rd_ptr     = rd_ptr;
        if (frame_event) begin
            next_active_sel = ~active_sel;
            next_rd_ptr     = iso_dbuf_pkg::CNT_ZERO;
        end else if (cpu_rd_take) begin
            next_rd_ptr = rd_ptr + iso_dbuf_pkg::CNT_ONE;
        end
        // commands keep selection
        // Commit and release only touch counts and flags below, never next_active_sel
        for (int b = 0; b < 2; b++) begin
            next_cnt[b]       = cnt[b];
            next_committed[b] = committed[b];
            if (frame_event) begin
                next_committed[b] = 1'b0;
                if (b == int'(active_sel)) begin
                    if (!ep_dir_in || !committed[b]) begin
                        next_cnt[b] = iso_dbuf_pkg::CNT_ZERO;
                    end
                end else if (ep_dir_in) begin
                    next_cnt[b] = iso_dbuf_pkg::CNT_ZERO;
                end
            end else if (b == int'(active_sel)) begin
                if (cpu_wr_take) begin
                    next_cnt[b] = cnt[b] + iso_dbuf_pkg::CNT_ONE;
                end
                if (cpu_commit && ep_dir_in) begin
                    next_committed[b] = 1'b1;
                end
                if (cpu_release && !ep_dir_in) begin
                    next_cnt[b] = iso_dbuf_pkg::CNT_ZERO;
                end
            end else if (rx_take) begin
                next_cnt[b] = cnt[b] + iso_dbuf_pkg::CNT_ONE;
            end
        end
        // Handshake outputs are precomputed from next state so they leave straight from flops
        next_cpu_wr_ready = ep_dir_in & ~next_committed[next_active_sel]
                            & (next_cnt[next_active_sel] != iso_dbuf_pkg::CNT_FULL);
        // The wide read count tells a drained full buffer from a fresh one, so no read wraps around
        next_cpu_rd_avail = ~ep_dir_in & (next_rd_ptr < next_cnt[next_active_sel]);
        next_cpu_rd_valid = cpu_rd_take;
        next_cpu_rd_data  = cpu_rd_take ? endpoint_packet_ram[{active_sel, rd_ptr[5:0]}] : cpu_rd_data;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            active_sel   <= iso_dbuf_pkg::ACT_RST;
            rd_ptr       <= iso_dbuf_pkg::CNT_ZERO;
            cnt[0]       <= iso_dbuf_pkg::CNT_ZERO;
            cnt[1]       <= iso_dbuf_pkg::CNT_ZERO;
            committed[0] <= 1'b0;
            committed[1] <= 1'b0;
            cpu_wr_ready <= 1'b0;
            cpu_rd_valid <= 1'b0;
            cpu_rd_data  <= iso_dbuf_pkg::DATA_ZERO;
            cpu_rd_avail <= 1'b0;
        end else if (clk_en) begin
            active_sel   <= next_active_sel;
            rd_ptr       <= next_rd_ptr;
            cnt[0]       <= next_cnt[0];
            cnt[1]       <= next_cnt[1];
            committed[0] <= next_committed[0];
            committed[1] <= next_committed[1];
            cpu_wr_ready <= next_cpu_wr_ready;
            cpu_rd_valid <= next_cpu_rd_valid;
            cpu_rd_data  <= next_cpu_rd_data;
            cpu_rd_avail <= next_cpu_rd_avail;
        end
    end

    // ------------------------------------------------------------
    // Transmit sequencer for the bus-side IN buffer
    // ------------------------------------------------------------
    // A new frame restarts the sequencer; bytes already in the skid buffer still go out
    always_comb begin
        next_tx_state = tx_state;
        next_tx_len   = tx_len;
        next_tx_ptr   = tx_ptr;
        push          = 1'b0;
        push_data     = endpoint_packet_ram[{~active_sel, tx_ptr}];
        push_last     = (tx_ptr == 6'(tx_len - iso_dbuf_pkg::CNT_ONE));
        push_zlp      = 1'b0;
        if (frame_event && ep_dir_in) begin
            next_tx_len   = committed[active_sel] ? cnt[active_sel] : iso_dbuf_pkg::CNT_ZERO;
            next_tx_ptr   = iso_dbuf_pkg::PTR_ZERO;
            next_tx_state = committed[active_sel] && cnt[active_sel] != iso_dbuf_pkg::CNT_ZERO
                            ? iso_dbuf_pkg::TX_DATA : iso_dbuf_pkg::TX_ZLP;
        end else begin
            unique case (tx_state)
                iso_dbuf_pkg::TX_IDLE: next_tx_state = iso_dbuf_pkg::TX_IDLE;
                iso_dbuf_pkg::TX_DATA: begin
                    if (!skid_valid) begin
                        push        = 1'b1;
                        next_tx_ptr = tx_ptr + 6'h01;
                        if (push_last) begin
                            next_tx_state = iso_dbuf_pkg::TX_IDLE;
                        end
                    end
                end
                iso_dbuf_pkg::TX_ZLP: begin
                    if (!skid_valid) begin
                        push          = 1'b1;
                        push_last     = 1'b1;
                        push_zlp      = 1'b1;
                        push_data     = iso_dbuf_pkg::DATA_ZERO;
                        next_tx_state = iso_dbuf_pkg::TX_IDLE;
                    end
                end
                default: next_tx_state = iso_dbuf_pkg::TX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Two-entry skid buffer toward the serial engine
    // ------------------------------------------------------------
    // The second entry catches a byte when the engine stalls, and its fullness stalls the sequencer
    always_comb begin
        next_se_tx_valid = se_tx_valid;
        next_se_tx_data  = se_tx_data;
        next_se_tx_last  = se_tx_last;
        next_se_tx_zlp   = se_tx_zlp;
        next_skid_valid  = skid_valid;
        next_skid_data   = skid_data;
        next_skid_last   = skid_last;
        next_skid_zlp    = skid_zlp;
        if (!se_tx_valid || se_tx_ready) begin
            if (skid_valid) begin
                next_se_tx_valid = 1'b1;
                next_se_tx_data  = skid_data;
                next_se_tx_last  = skid_last;
                next_se_tx_zlp   = skid_zlp;
                next_skid_valid  = 1'b0;
            end else begin
                next_se_tx_valid = push;
                next_se_tx_data  = push_data;
                next_se_tx_last  = push_last;
                next_se_tx_zlp   = push_zlp;
            end
        end else if (push) begin
            next_skid_valid = 1'b1;
            next_skid_data  = push_data;
            next_skid_last  = push_last;
            next_skid_zlp   = push_zlp;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_state    <= iso_dbuf_pkg::TX_IDLE;
            tx_len      <= iso_dbuf_pkg::CNT_ZERO;
            tx_ptr      <= iso_dbuf_pkg::PTR_ZERO;
            se_tx_valid <= 1'b0;
            se_tx_data  <= iso_dbuf_pkg::DATA_ZERO;
            se_tx_last  <= 1'b0;
            se_tx_zlp   <= 1'b0;
            skid_valid  <= 1'b0;
            skid_data   <= iso_dbuf_pkg::DATA_ZERO;
            skid_last   <= 1'b0;
            skid_zlp    <= 1'b0;
        end else if (clk_en) begin
            tx_state    <= next_tx_state;
            tx_len      <= next_tx_len;
            tx_ptr      <= next_tx_ptr;
            se_tx_valid <= next_se_tx_valid;
            se_tx_data  <= next_se_tx_data;
            se_tx_last  <= next_se_tx_last;
            se_tx_zlp   <= next_se_tx_zlp;
            skid_valid  <= next_skid_valid;
            skid_data   <= next_skid_data;
            skid_last   <= next_skid_last;
            skid_zlp    <= next_skid_zlp;
        end
    end

endmodule

/* rtl/iso_dbuf_pkg.sv */
// Constants shared by the isochronous double-buffer endpoint logic.
// Assumes one endpoint per instance and byte-wide packet data.
package iso_dbuf_pkg;

    // ------------------------------------------------------------
    // Packet memory geometry
    // ------------------------------------------------------------
    localparam int unsigned PKT_DEPTH = 64;              // Bytes per packet buffer
    localparam int unsigned PTR_W     = 6;               // Index within one buffer
    localparam int unsigned CNT_W     = 7;               // Fill count, 0 to PKT_DEPTH
    localparam int unsigned RAM_AW    = 7;               // Buffer select plus index
    localparam int unsigned DATA_W    = 8;
    localparam logic [6:0]  CNT_FULL  = 7'h40;           // Count of a full buffer
    localparam logic [6:0]  CNT_ZERO  = 7'h00;
    localparam logic [6:0]  CNT_ONE   = 7'h01;
    localparam logic [5:0]  PTR_ZERO  = 6'h00;
    localparam logic [7:0]  DATA_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic        ACT_RST   = 1'b0;            // Buffer 0 starts active

    // ------------------------------------------------------------
    // Transmit sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_DATA = 2'b01,
        TX_ZLP  = 2'b10
    } tx_state_t;

endpackage

/* dv/iso_dbuf_monitor.sv */
// Checker for the isochronous double-buffer endpoint, bound to its top module.
// Assumes one mclk domain with a synchronous active-high reset.
`timescale 1ns/1ps
module iso_dbuf_monitor (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       clk_en,
    input wire logic       ep_dir_in,
    input wire logic       frame_event,
    input wire logic       cpu_commit,
    input wire logic       cpu_rd_req,
    input wire logic       cpu_rd_valid,
    input wire logic       cpu_wr_ready,
    input wire logic       active_sel,
    input wire logic       se_tx_valid,
    input wire logic [7:0] se_tx_data,
    input wire logic       se_tx_last,
    input wire logic       se_tx_zlp,
    input wire logic       se_tx_ready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Buffer roles and stream shape
    // ------------------------------------------------------------
    a_swap_on_frame: assert property (frame_event && clk_en |=> active_sel != $past(active_sel))
        else $error("active buffer did not swap");
    a_sel_held: assert property (!(frame_event && clk_en) |=> $stable(active_sel))
        else $error("active buffer moved without frame");
    a_commit_closes: assert property (cpu_commit && clk_en && ep_dir_in && !frame_event |=> ##[0:1] !cpu_wr_ready)
        else $error("committed buffer still takes writes");
    a_read_cause: assert property (cpu_rd_valid |-> $past(cpu_rd_req) && $past(clk_en))
        else $error("read data without request");
    a_read_out_only: assert property (cpu_rd_valid |-> !ep_dir_in)
        else $error("read data on IN endpoint");
    a_zlp_shape: assert property (se_tx_zlp && se_tx_valid |-> se_tx_last && se_tx_data == 8'h00)
        else $error("empty packet entry malformed");
    a_tx_held: assert property (se_tx_valid && !se_tx_ready |=> se_tx_valid && $stable(se_tx_data))
        else $error("stalled stream head changed");
    a_tx_start: assert property (frame_event && clk_en && ep_dir_in && !se_tx_valid |-> ##2 se_tx_valid)
        else $error("no packet two cycles after frame");
endmodule
bind usb_iso_endpoint_double_buffer iso_dbuf_monitor mon_u (.mclk(mclk), .rst(rst), .clk_en(clk_en),
    .ep_dir_in(ep_dir_in), .frame_event(frame_event), .cpu_commit(cpu_commit), .cpu_rd_req(cpu_rd_req),
    .cpu_rd_valid(cpu_rd_valid), .cpu_wr_ready(cpu_wr_ready), .active_sel(active_sel),
    .se_tx_valid(se_tx_valid), .se_tx_data(se_tx_data), .se_tx_last(se_tx_last), .se_tx_zlp(se_tx_zlp),
    .se_tx_ready(se_tx_ready));

/* dv/serial_engine_model.sv */
// Serial engine model: the bus side of the endpoint in both directions.
// Assumes mclk only; the bench calls send and reads got_b and got_len.
`timescale 1ns/1ps
module serial_engine_model (
    input  wire logic       mclk,
    input  wire logic       se_tx_valid,
    input  wire logic [7:0] se_tx_data,
    input  wire logic       se_tx_last,
    input  wire logic       se_tx_zlp,
    output logic            se_tx_ready,
    output logic            se_rx_valid,
    output logic [7:0]      se_rx_data
);
    logic slow = 1'b0;
    int   cur = 0;
    int   got_b[$];
    int   got_len[$];
    initial begin
        se_tx_ready = 1'b0;
        se_rx_valid = 1'b0;
        se_rx_data = 8'ha5;
    end
    // Take the stream head; a slow engine stalls at random so the skid path is used
    always @(posedge mclk) begin
        if (se_tx_valid === 1'b1 && se_tx_ready) begin
            if (se_tx_zlp) got_len.push_back(0);
            else begin
                got_b.push_back(se_tx_data);
                cur++;
                if (se_tx_last) begin
                    got_len.push_back(cur);
                    cur = 0;
                end
            end
        end
        #1 se_tx_ready = slow ? 1'($urandom % 2) : 1'b1;
    end
    // Received bytes back to back; idle line shows the inverse so stale data is not mistaken
    task automatic send(input int q[$]);
        foreach (q[i]) begin
            se_rx_valid = 1'b1;
            se_rx_data = 8'(q[i]);
            @(posedge mclk);
            #1;
        end
        se_rx_valid = 1'b0;
        se_rx_data = ~se_rx_data;
    endtask
endmodule

/* dv/usb_iso_endpoint_double_buffer_bench.sv */
// Self-checking bench for the isochronous double-buffer endpoint.
// Assumes the serial engine model beside it and one 20 MHz clock.
`timescale 1ns/1ps
module usb_iso_endpoint_double_buffer_bench;
    logic       mclk = 1'b0, rst = 1'b1, clk_en = 1'b1, ep_dir_in = 1'b0, frame_event = 1'b0;
    logic       cpu_wr_valid = 1'b0, cpu_commit = 1'b0, cpu_release = 1'b0, cpu_rd_req = 1'b0;
    logic [7:0] cpu_wr_data = 8'h00;
    logic       cpu_wr_ready, cpu_rd_valid, cpu_rd_avail, active_sel, se_rx_valid;
    logic       se_tx_valid, se_tx_last, se_tx_zlp, se_tx_ready, exp_sel = 1'b0, comm = 1'b0;
    logic [7:0] cpu_rd_data, se_rx_data, se_tx_data;
    int         err_count = 0, n_checks = 0, cycles = 0, n, k;
    int         act_q[$], bus_q[$], exp_b[$], exp_len[$];

    always #25 mclk = ~mclk;

    usb_iso_endpoint_double_buffer dut_u (.mclk(mclk), .rst(rst), .clk_en(clk_en), .ep_dir_in(ep_dir_in),
        .frame_event(frame_event), .cpu_wr_valid(cpu_wr_valid), .cpu_wr_data(cpu_wr_data),
        .cpu_wr_ready(cpu_wr_ready), .cpu_commit(cpu_commit), .cpu_release(cpu_release),
        .cpu_rd_req(cpu_rd_req), .cpu_rd_valid(cpu_rd_valid), .cpu_rd_data(cpu_rd_data),
        .cpu_rd_avail(cpu_rd_avail), .active_sel(active_sel), .se_rx_valid(se_rx_valid),
        .se_rx_data(se_rx_data), .se_tx_valid(se_tx_valid), .se_tx_data(se_tx_data),
        .se_tx_last(se_tx_last), .se_tx_zlp(se_tx_zlp), .se_tx_ready(se_tx_ready));
    serial_engine_model se_u (.mclk(mclk), .se_tx_valid(se_tx_valid), .se_tx_data(se_tx_data),
        .se_tx_last(se_tx_last), .se_tx_zlp(se_tx_zlp), .se_tx_ready(se_tx_ready),
        .se_rx_valid(se_rx_valid), .se_rx_data(se_rx_data));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic summarize();
        if (err_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    // Valid stays up between bytes so a burst is back to back
    // Ready is a flop, so looking at it off the edge tells whether the next edge takes the byte
    task automatic wr(input logic [7:0] b);
        cpu_wr_valid = 1'b1;
        cpu_wr_data = b;
        while (cpu_wr_ready !== 1'b1) tick();
        tick();
    endtask
    task automatic rd_n(input int cnt);
        for (int i = 0; i < cnt; i++) begin
            cpu_rd_req = 1'b1;
            tick();
            chk({7'h00, cpu_rd_valid}, 8'h01);
            chk(cpu_rd_data, 8'(act_q.pop_front()));
        end
        cpu_rd_req = 1'b0;
    endtask
    // Frame boundary: reference model swaps, drops unread OUT data, queues the IN packet
    task automatic frame();
        frame_event = 1'b1;
        tick();
        frame_event = 1'b0;
        exp_sel = ~exp_sel;
        if (ep_dir_in) begin
            if (comm && act_q.size() > 0) begin
                exp_len.push_back(act_q.size());
                foreach (act_q[i]) exp_b.push_back(act_q[i]);
            end else exp_len.push_back(0);
            comm = 1'b0;
            act_q = {};
        end else begin
            act_q = bus_q;
            bus_q = {};
        end
        chk({7'h00, active_sel}, {7'h00, exp_sel});
        chk({7'h00, cpu_rd_avail}, (!ep_dir_in && act_q.size() > 0) ? 8'h01 : 8'h00);
    endtask

    // Hang guard: the tests need about 2000 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hdd6ac26b));
        repeat (16) @(posedge mclk);
        #1 rst = 1'b0;
        tick();
        // OUT: bus fills the idle buffer while the active one is partly read
        for (int i = 0; i < 3; i++) begin
            n = (i == 1) ? 64 : 1 + $urandom % 63;
            for (int j = 0; j < n; j++) bus_q.push_back($urandom % 256);
            k = $urandom % (act_q.size() + 1);
            fork
                se_u.send(bus_q);
                rd_n(k);
            join
            frame();
        end
        cpu_release = 1'b1;
        act_q = {};
        tick();
        cpu_release = 1'b0;
        tick();
        tick();
        chk({7'h00, cpu_rd_avail}, 8'h00);
        chk({7'h00, active_sel}, {7'h00, exp_sel});
        cpu_rd_req = 1'b1;
        tick();
        cpu_rd_req = 1'b0;
        chk({7'h00, cpu_rd_valid}, 8'h00);
        // Frozen clock enable swallows a frame pulse
        clk_en = 1'b0;
        frame_event = 1'b1;
        tick();
        frame_event = 1'b0;
        clk_en = 1'b1;
        tick();
        chk({7'h00, active_sel}, {7'h00, exp_sel});
        // IN: full, uncommitted, committed, reused and empty buffers
        ep_dir_in = 1'b1;
        repeat (4) tick();
        for (int j = 0; j < 5; j++) begin
            n = (j == 0) ? 64 : (j == 4) ? 0 : 1 + $urandom % 63;
            for (int b = 0; b < n; b++) begin
                act_q.push_back($urandom % 256);
                wr(8'(act_q[b]));
            end
            cpu_wr_valid = 1'b0;
            tick();
            if (n == 64) chk({7'h00, cpu_wr_ready}, 8'h00);
            if (j != 1 && j != 4) begin
                cpu_commit = 1'b1;
                comm = 1'b1;
                tick();
                cpu_commit = 1'b0;
                tick();
                chk({7'h00, cpu_wr_ready}, 8'h00);
                chk({7'h00, active_sel}, {7'h00, exp_sel});
            end
            se_u.slow = j[0];
            // A stalling engine loses a cycle per stall, so leave room for a full slow packet
            repeat (300) tick();
            frame();
        end
        repeat (200) tick();
        chk(8'(se_u.got_len.size()), 8'(exp_len.size()));
        foreach (exp_len[i]) chk(8'(se_u.got_len[i]), 8'(exp_len[i]));
        foreach (exp_b[i]) chk(8'(se_u.got_b[i]), 8'(exp_b[i]));
        summarize();
    end
endmodule
